// >>> common/ssfm_cfg.svh
`ifndef SSFM_CFG_SVH
`define SSFM_CFG_SVH

// Clock and monitor timing
`define SSFM_CLK_NS 10
`define SSFM_MS_NS 1000000
`define SSFM_MS_CYC (`SSFM_MS_NS / `SSFM_CLK_NS)

// Command opcodes
`define SSFM_OPC_READ 7'h58
`define SSFM_OPC_ROUTE 5'h18
`define SSFM_OPC_SETUP 8'hd0
`define SSFM_OPC_CLEAR 8'hff

// Setup field codes
`define SSFM_VOLT_OFF 3'h0
`define SSFM_TEMP_ON 2'h3
`define SSFM_IVL_CONT 3'h0

// Reset values
`define SSFM_SETUP_RST 8'h39
`define SSFM_ROUTE_RST 3'h0

// Register offsets on the bus
`define SSFM_REG_CTRL 8'h00
`define SSFM_REG_FAULT 8'h04
`define SSFM_REG_CONFIG 8'h08
`define SSFM_REG_CHAN 8'h0c

// Field positions
`define SSFM_CTRL_TWICE 0
`define SSFM_FAULT_PIN 3
`define SSFM_CONFIG_ROUTE 8

`endif

// >>> common/ssfm_pkg.sv
package ssfm_pkg;

   // Second byte of the fail-safe setup command
   typedef struct packed {
      logic [2:0] monitorIntervalField;
      logic [1:0] tempLevelField;
      logic [2:0] voltLevelField;
   } ssfm_setup_t;

   // Status pin routing selection
   typedef struct packed {
      logic flagSelectBit;
      logic [1:0] channelSelectField;
   } ssfm_route_t;

   // Sticky fail-safe flags, in status-byte order D2..D0
   typedef struct packed {
      logic overtempFlag;
      logic undervoltFlag;
      logic transferFaultFlag;
   } ssfm_fault_t;

   // Per-channel flags from the playback engines
   typedef struct packed {
      logic [3:0] playingNFlag;
      logic [3:0] cmdReadyFlag;
   } ssfm_chan_t;

   // Command parser states, Gray along the usual path
   typedef enum logic [2:0] {
      S_CMD = 3'h0,
      S_CMD_DUP = 3'h1,
      S_ARG = 3'h3,
      S_ARG_DUP = 3'h2,
      S_READ = 3'h6
   } ssfm_state_t;

endpackage

// >>> hw/ssfm_top.sv
// Operation
// - Status read opcode 1011000 plus source bit
// - Source 0 channel flags, 1 fault flags
// - Byte: busy flags high nibble, ready low
// - Ready low while busy; busy_n low playing
// - Fault byte: zeros, overtemp, undervolt, transfer
// - Any detection raises pin and sets flag
// - Duplicate mismatch in twice mode flags transfer
// - Route opcode 11000, flag select, channel
// - Channel field binary; channel 0 after reset
// - Setup: d0 then interval, temp, volt
// - Voltage level codes, 001 default
// - Two low samples raise undervolt error
// - Temperature codes 00 off, 11 default
// - Two hot samples raise overtemp error
// - Interval codes: continuous, 2 to 128 ms
// - Clear command 0xff lowers error pin
// - Analog faults persist until condition gone
// - Setup two bytes; route, clear one byte
`timescale 1ns/100ps
`include "ssfm_cfg.svh"

module ssfm_top #(
   parameter int MS_CYCLES = `SSFM_MS_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic serClk,
   input wire logic serSelN,
   input wire logic serDin,
   output logic serDout,
   input wire ssfm_pkg::ssfm_chan_t chanFlags,
   input wire logic voltLow,
   input wire logic tempHigh,
   output ssfm_pkg::ssfm_setup_t monitorSetup,
   output logic errPin,
   output logic statusPin
);
   import ssfm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Upper seven bits match the status read opcode
   function automatic logic isReadCmd(input logic [7:0] b);
      isReadCmd = (b[7:1] == `SSFM_OPC_READ);
   endfunction

   // Upper five bits match the routing opcode
   function automatic logic isRouteCmd(input logic [7:0] b);
      isRouteCmd = (b[7:3] == `SSFM_OPC_ROUTE);
   endfunction

   // Monitor interval length in milliseconds, code 1 gives 2 ms
   function automatic logic [7:0] intervalMs(input logic [2:0] code);
      intervalMs = 8'h01 << code;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin input conditioning

   logic [2:0] clkSync;
   logic [2:0] selSync;
   logic [2:0] dinSync;
   logic [2:0] voltSync;
   logic [2:0] tempSync;
   logic clkF;
   logic selNF;
   logic dinF;
   logic voltF;
   logic tempF;
   logic clkPrev;

   // Three stages; a level counts only once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clkSync <= 3'h0;
         selSync <= 3'h7;
         dinSync <= 3'h0;
         voltSync <= 3'h0;
         tempSync <= 3'h0;
      end else begin
         clkSync <= {clkSync[1:0], serClk};
         selSync <= {selSync[1:0], serSelN};
         dinSync <= {dinSync[1:0], serDin};
         voltSync <= {voltSync[1:0], voltLow};
         tempSync <= {tempSync[1:0], tempHigh};
      end
   end

   // Filtered levels; the first stage feeds nothing but the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clkF <= 1'b0;
         selNF <= 1'b1;
         dinF <= 1'b0;
         voltF <= 1'b0;
         tempF <= 1'b0;
         clkPrev <= 1'b0;
      end else begin
         if (clkSync[2] == clkSync[1]) clkF <= clkSync[2];
         if (selSync[2] == selSync[1]) selNF <= selSync[2];
         if (dinSync[2] == dinSync[1]) dinF <= dinSync[2];
         if (voltSync[2] == voltSync[1]) voltF <= voltSync[2];
         if (tempSync[2] == tempSync[1]) tempF <= tempSync[2];
         clkPrev <= clkF;
      end
   end

   wire sckRise = clkF & ~clkPrev & ~selNF;
   wire sckFall = ~clkF & clkPrev & ~selNF;

   ////////////////////////////////////////////////////////////////////////
   // Serial byte receiver, MSB first, sampled on the rising edge

   logic [2:0] bitCnt;
   logic [6:0] rxShift;
   logic [7:0] rxByte;
   logic byteDone;

   // Deselect drops a partial byte so framing recovers cleanly
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bitCnt <= 3'h0;
         rxShift <= 7'h00;
         rxByte <= 8'h00;
         byteDone <= 1'b0;
      end else begin
         byteDone <= sckRise && (bitCnt == 3'h7);
         if (selNF) begin
            bitCnt <= 3'h0;
         end else if (sckRise) begin
            bitCnt <= bitCnt + 3'h1;
            rxShift <= {rxShift[5:0], dinF};
            if (bitCnt == 3'h7) rxByte <= {rxShift, dinF};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command parser

   logic twiceMode;
   ssfm_state_t state;
   ssfm_state_t next_state;
   logic [7:0] pend;
   logic [7:0] next_pend;
   logic execCmd;
   logic execArg;
   logic [7:0] execByte;
   logic dupMismatch;

   // In twice mode every command and setup argument byte arrives twice; a differing copy is a fault
   always_comb begin
      next_state = state;
      next_pend = pend;
      execCmd = 1'b0;
      execArg = 1'b0;
      execByte = rxByte;
      dupMismatch = 1'b0;
      if (byteDone) begin
         case (state)
            S_CMD: begin
               if (twiceMode) begin
                  next_state = S_CMD_DUP;
                  next_pend = rxByte;
               end else begin
                  execCmd = 1'b1;
               end
            end
            S_CMD_DUP: begin
               execByte = pend;
               execCmd = (rxByte == pend);
               dupMismatch = (rxByte != pend);
               next_state = S_CMD;
            end
            S_ARG: begin
               if (twiceMode) begin
                  next_state = S_ARG_DUP;
                  next_pend = rxByte;
               end else begin
                  execArg = 1'b1;
               end
            end
            S_ARG_DUP: begin
               execByte = pend;
               execArg = (rxByte == pend);
               dupMismatch = (rxByte != pend);
               next_state = S_CMD;
            end
            S_READ: begin
               next_state = S_CMD; // Readback byte carries no command
            end
            default: begin
               next_state = S_CMD;
            end
         endcase
         if (execArg) next_state = S_CMD;
         if (execCmd) begin
            if (execByte == `SSFM_OPC_SETUP) next_state = S_ARG;
            else if (isReadCmd(execByte)) next_state = S_READ;
            else next_state = S_CMD;
         end
      end
   end

   wire doRead = execCmd & isReadCmd(execByte);
   wire doRoute = execCmd & isRouteCmd(execByte);
   wire doClear = execCmd & (execByte == `SSFM_OPC_CLEAR);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_CMD;
         pend <= 8'h00;
      end else begin
         state <= next_state;
         pend <= next_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Setup and routing registers

   ssfm_route_t route;

   // Setup second byte is taken whole; routing takes the low three bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         monitorSetup <= ssfm_setup_t'(`SSFM_SETUP_RST);
         route <= ssfm_route_t'(`SSFM_ROUTE_RST);
      end else begin
         if (execArg) monitorSetup <= ssfm_setup_t'(execByte);
         if (doRoute) route <= ssfm_route_t'(execByte[2:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status pin routing

   wire [1:0] routeCh = route.channelSelectField;
   wire routeBit = route.flagSelectBit ? chanFlags.playingNFlag[routeCh]
                                       : chanFlags.cmdReadyFlag[routeCh];

   // Re-registered so the pin never glitches across a routing change
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) statusPin <= 1'b0;
      else statusPin <= routeBit;
   end

   ////////////////////////////////////////////////////////////////////////
   // Monitor sampling clock

   logic [31:0] msCnt;
   logic [7:0] msIdx;
   wire msTick = (msCnt == 32'(MS_CYCLES - 1));
   wire [2:0] ivl = monitorSetup.monitorIntervalField;
   wire ivlEnd = msTick && (msIdx == intervalMs(ivl) - 8'h01);
   wire sampleTick = (ivl == `SSFM_IVL_CONT) | ivlEnd;

   // Millisecond divider, then milliseconds within the interval
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         msCnt <= 32'h0;
         msIdx <= 8'h00;
      end else begin
         msCnt <= msTick ? 32'h0 : msCnt + 32'h1;
         if (ivlEnd || msIdx >= intervalMs(ivl)) msIdx <= 8'h00;
         else if (msTick) msIdx <= msIdx + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Threshold detection, two hits in a row

   wire voltOn = (monitorSetup.voltLevelField != `SSFM_VOLT_OFF);
   wire tempOn = (monitorSetup.tempLevelField == `SSFM_TEMP_ON);
   logic [1:0] voltHits;
   logic [1:0] tempHits;
   wire voltHit = voltOn & voltF;
   wire tempHit = tempOn & tempF;
   wire voltDetect = sampleTick & voltHit & (voltHits != 2'h0);
   wire tempDetect = sampleTick & tempHit & (tempHits != 2'h0);
   wire voltGone = ~voltHit; // Last look found the supply healthy
   wire tempGone = ~tempHit;

   // A single good sample restarts the count; one glitch never trips
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         voltHits <= 2'h0;
         tempHits <= 2'h0;
      end else begin
         if (!voltOn) voltHits <= 2'h0;
         else if (sampleTick) voltHits <= voltHit ? 2'h2 : 2'h0;
         if (!tempOn) tempHits <= 2'h0;
         else if (sampleTick) tempHits <= tempHit ? 2'h2 : 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault flags and error pin

   ssfm_fault_t fault;
   ssfm_fault_t next_fault;
   logic voltClrPend;
   logic tempClrPend;

   // Set always wins over clear; analog faults wait for the fault to go
   always_comb begin
      next_fault = fault;
      if (doClear) next_fault.transferFaultFlag = 1'b0;
      if ((doClear || voltClrPend) && voltGone) begin
         next_fault.undervoltFlag = 1'b0;
      end
      if ((doClear || tempClrPend) && tempGone) begin
         next_fault.overtempFlag = 1'b0;
      end
      if (dupMismatch) next_fault.transferFaultFlag = 1'b1;
      if (voltDetect) next_fault.undervoltFlag = 1'b1;
      if (tempDetect) next_fault.overtempFlag = 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault <= ssfm_fault_t'(3'h0);
         errPin <= 1'b0;
         voltClrPend <= 1'b0;
         tempClrPend <= 1'b0;
      end else begin
         fault <= next_fault;
         errPin <= |next_fault;
         voltClrPend <= next_fault.undervoltFlag & (voltClrPend | doClear);
         tempClrPend <= next_fault.overtempFlag & (tempClrPend | doClear);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status readback shifter

   wire [7:0] chanByte = {chanFlags.playingNFlag,
                          chanFlags.cmdReadyFlag};
   wire [7:0] faultByte = {5'h00, fault};
   wire [7:0] statusByte = execByte[0] ? faultByte : chanByte;
   logic [7:0] txShift;

   // Shift only on falls inside a byte, so the fall that ends the
   // command byte cannot eat bit 7 before the host samples it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) txShift <= 8'h00;
      else if (doRead) txShift <= statusByte;
      else if (sckFall && bitCnt != 3'h0) txShift <= {txShift[6:0], 1'b0};
   end

   assign serDout = txShift[7];

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wbWr = wbReq & wb_we_i;
   wire selCtrl = (wb_adr_i == `SSFM_REG_CTRL);
   wire [31:0] configWord = {21'h0, route, monitorSetup};
   wire [31:0] faultWord = {28'h0, errPin, fault};
   wire [31:0] rdMux = selCtrl ? {31'h0, twiceMode}
                     : (wb_adr_i == `SSFM_REG_FAULT) ? faultWord
                     : (wb_adr_i == `SSFM_REG_CONFIG) ? configWord
                     : (wb_adr_i == `SSFM_REG_CHAN) ? {24'h0, chanByte}
                     : 32'h0;

   // One-cycle answer; unmapped offsets ack with zero and ignore writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         twiceMode <= 1'b0;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= wbReq ? rdMux : 32'h0;
         if (wbWr && selCtrl && wb_sel_i[0]) begin
            twiceMode <= wb_dat_i[`SSFM_CTRL_TWICE];
         end
      end
   end

endmodule

// >>> verif/ssfm_checker.sv
`timescale 1ns/100ps
module ssfm_checker #(
   parameter int MS_CYCLES = 10
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic serClk,
   input wire logic serSelN,
   input wire logic serDin,
   input wire logic serDout,
   input wire ssfm_pkg::ssfm_chan_t chanFlags,
   input wire logic voltLow,
   input wire logic tempHigh,
   input wire ssfm_pkg::ssfm_setup_t monitorSetup,
   input wire logic errPin,
   input wire logic statusPin
);
   import ssfm_pkg::*;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Supply monitor armed and sampling every cycle
   wire voltHit = voltLow && monitorSetup.voltLevelField != 3'h0
      && monitorSetup.monitorIntervalField == 3'h0;

   ////////////////////////////////////////////////////////////////////
   // Bus handshake
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not answered");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i)
      && $past(wb_stb_i)) else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");

   ////////////////////////////////////////////////////////////////////
   // Pins
   a_setup_reset: assert property ($rose(arst_n) |->
      monitorSetup == 8'h39) else $error("setup reset value wrong");
   a_status_ones: assert property (chanFlags == 8'hff |=>
      statusPin) else $error("status pin low with all flags high");
   a_status_zero: assert property (chanFlags == 8'h00 |=>
      !statusPin) else $error("status pin high with all flags low");
   a_volt_err: assert property (voltHit [*8] |->
      ##[0:4] errPin) else $error("low supply did not raise error");
   a_err_fall: assert property ($fell(errPin) |->
      !voltLow && !tempHigh) else $error("error fell with fault present");

   // Main scenarios
   c_write: cover property (wb_ack_o && wb_we_i);
   c_err_up: cover property ($rose(errPin));
   c_err_down: cover property ($fell(errPin));
endmodule

// >>> verif/ssfm_host.sv
`timescale 1ns/100ps
module ssfm_host (
   input wire logic clk,
   input wire logic serDout,
   output logic serClk,
   output logic serSelN,
   output logic serDin
);
   // Link idles with clock low and device deselected
   initial begin
      serClk = 1'b0;
      serSelN = 1'b1;
      serDin = 1'b0;
   end

   // Sends n bytes of tx, left aligned; rx is the last byte read back.
   // Clock stands still outside the frame, as a real host would.
   task automatic frame(input int n, input logic [31:0] tx,
         output logic [7:0] rx);
      @(posedge clk);
      serSelN <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8 * n; i++) begin
         serDin <= tx[31 - i];
         repeat (4) @(posedge clk);
         serClk <= 1'b1;
         repeat (4) @(posedge clk);
         // Sampled late in the high phase: the device only answers a fall
         // after its input synchroniser, later than the next rise
         rx = {rx[6:0], serDout};
         serClk <= 1'b0;
         if (i % 8 == 7)
            repeat (8) @(posedge clk);
      end
      serSelN <= 1'b1;
      serDin <= ~serDin; // Released line must not look stable
      repeat (16) @(posedge clk);
   endtask
endmodule

// >>> verif/tb_status_readout_failsafe_monitor.sv
`timescale 1ns/100ps
module tb_status_readout_failsafe_monitor;
   import ssfm_pkg::*;
   localparam int MS = 10;

   logic clk = 1'b0;
   logic arstN = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'hf;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   logic serClk, serSelN, serDin, serDout;
   ssfm_chan_t chanFlags = 8'hff;
   logic voltLow = 1'b0;
   logic tempHigh = 1'b0;
   ssfm_setup_t monitorSetup;
   logic errPin, statusPin;
   int n_errors = 0;
   int compares = 0;
   int seed = 32'h190b;
   logic ot = 1'b0;
   logic uv = 1'b0;
   logic tf = 1'b0;
   logic twice = 1'b0;

   always #5 clk = ~clk;

   ssfm_top #(.MS_CYCLES(MS)) u_dut (.clk(clk), .arst_n(arstN),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .serClk(serClk),
      .serSelN(serSelN), .serDin(serDin), .serDout(serDout),
      .chanFlags(chanFlags), .voltLow(voltLow), .tempHigh(tempHigh),
      .monitorSetup(monitorSetup), .errPin(errPin),
      .statusPin(statusPin));

   ssfm_host u_host (.clk(clk), .serDout(serDout), .serClk(serClk),
      .serSelN(serSelN), .serDin(serDin));

   ////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      int t;
      t = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= d;
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1 && t < 20);
      r = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (t >= 20)
         chk("wb ack", 1, 0);
   endtask

   // Host reaction to the error pin: read flags both ways
   task automatic chk_faults();
      logic [31:0] r;
      logic [7:0] b;
      wb(1'b0, 8'h04, 32'h0, r);
      chk("fault reg", {ot | uv | tf, ot, uv, tf}, r);
      if (twice)
         u_host.frame(3, 32'hb1b10000, b);
      else
         u_host.frame(2, 32'hb1000000, b);
      chk("fault byte", {ot, uv, tf}, b);
      chk("err pin", ot | uv | tf, errPin);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [7:0] b, rnd;
      repeat (12) @(posedge clk);
      arstN <= 1'b1;
      repeat (6) @(posedge clk);
      chk("setup", 8'h39, monitorSetup);
      chk("status", chanFlags.cmdReadyFlag[0], statusPin);
      chanFlags <= 8'h00;
      repeat (3) @(posedge clk);
      wb(1'b0, 8'h00, 32'h0, r);
      chk("ctrl", 32'h0, r);
      wb(1'b0, 8'h08, 32'h0, r);
      chk("config", 32'h39, r);
      wb(1'b1, 8'h0c, 32'hff, r);
      wb(1'b0, 8'h0c, 32'h0, r);
      chk("chan", 32'h0, r);
      wb(1'b0, 8'h10, 32'h0, r);
      chk("unmapped", 32'h0, r);
      chk_faults();
      $display("test reset done");
      // Channel flag readback with random flags
      for (int i = 0; i < 4; i++) begin
         rnd = 8'($random(seed));
         chanFlags <= ssfm_chan_t'(rnd);
         u_host.frame(2, 32'hb0000000, b);
         chk("chan byte", rnd, b);
      end
      $display("test readback done");
      // Every route code, flags changed before each
      for (int c = 0; c < 8; c++) begin
         rnd = 8'($random(seed));
         chanFlags <= ssfm_chan_t'(rnd);
         u_host.frame(1, {5'h18, c[2:0], 24'h0}, b);
         chk("status", rnd[{c[2], c[1:0]}], statusPin);
         wb(1'b0, 8'h08, 32'h0, r);
         chk("route", c[2:0], r[10:8]);
      end
      $display("test route done");
      // Random setup arguments, temperature kept to legal codes
      for (int i = 0; i < 6; i++) begin
         rnd = 8'($random(seed));
         rnd[3] = rnd[4];
         u_host.frame(2, {8'hd0, rnd, 16'h0}, b);
         chk("setup", rnd, monitorSetup);
      end
      $display("test setup done");
      // Supply: off ignores it, 2.7 V level trips, clear waits
      u_host.frame(2, 32'hd0000000, b);
      voltLow <= 1'b1;
      repeat (30) @(posedge clk);
      chk_faults();
      u_host.frame(2, 32'hd0010000, b);
      repeat (30) @(posedge clk);
      uv = 1'b1;
      chk_faults();
      u_host.frame(1, 32'hff000000, b);
      chk_faults();
      voltLow <= 1'b0;
      repeat (30) @(posedge clk);
      uv = 1'b0;
      chk_faults();
      $display("test supply done");
      // Temperature at 8 ms: one sample is not enough
      u_host.frame(2, 32'hd0780000, b);
      tempHigh <= 1'b1;
      repeat (60) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0, r);
      chk("one hot sample", 1'b0, r[2]);
      repeat (140) @(posedge clk);
      ot = 1'b1;
      chk_faults();
      tempHigh <= 1'b0;
      u_host.frame(1, 32'hff000000, b);
      ot = 1'b0;
      chk_faults();
      $display("test temperature done");
      // Twice mode: mismatching copies, then a clean clear
      wb(1'b1, 8'h00, 32'h1, r);
      twice = 1'b1;
      u_host.frame(2, 32'hfffe0000, b);
      tf = 1'b1;
      chk_faults();
      u_host.frame(2, 32'hffff0000, b);
      tf = 1'b0;
      chk_faults();
      wb(1'b1, 8'h00, 32'h0, r);
      twice = 1'b0;
      $display("test twice done");
      stop_test();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end
endmodule

bind ssfm_top ssfm_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk),
   .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .serClk(serClk), .serSelN(serSelN), .serDin(serDin),
   .serDout(serDout), .chanFlags(chanFlags), .voltLow(voltLow),
   .tempHigh(tempHigh), .monitorSetup(monitorSetup), .errPin(errPin),
   .statusPin(statusPin));
